// File: msr_params.svh
// Constants for the multidrop serial responder: timing in bit times, address limits
`ifndef MSR_PARAMS_SVH
`define MSR_PARAMS_SVH
// Bit times in one byte on the wire: start, eight data, stop
`define MSR_BITS_PER_BYTE 16'h000a
// Nominal fixed response time, 2.5 byte periods in bit times
`define MSR_TR_NOM_BITS 16'h0019
// Extra margin against clock spread between units, half a byte
`define MSR_TR_MARGIN_BITS 16'h0005
// Length of the acknowledge reply in bytes
`define MSR_ACK_LEN_BYTES 16'h0006
// Highest usable unit address
`define MSR_ADDR_MAX 8'hfe
// Smallest clocks-per-bit the counters accept
`define MSR_DIV_MIN 16'h0002
// Line idle level and reset values
`define MSR_LINE_IDLE 1'b1
`define MSR_ZERO16 16'h0000
`endif

// File: msr_pkg.sv
// Types shared by the multidrop serial responder
`default_nettype none
package msr_pkg;
  // Link wiring as selected in the unit setup
  typedef enum logic [1:0] {
    MSR_LINK_P2P = 2'b00,
    MSR_LINK_FULL = 2'b01,
    MSR_LINK_HALF = 2'b10
  } msr_link_type;
  // Reply scheduler states
  typedef enum logic [1:0] {
    MSR_IDLE = 2'b00,
    MSR_WAIT = 2'b01,
    MSR_GRANT = 2'b10
  } msr_resp_type;
  // End-of-message report from the message parser
  typedef struct packed {
    logic done;
    logic bcast;
    logic [7:0] addr;
  } msr_msg_type;
endpackage : msr_pkg
`default_nettype wire

// File: msr_responder.sv
// Serial byte link with address filter and staggered broadcast reply scheduling
// What this block does
// - RS-232 and USB: no address filtering
// - Multidrop wiring: each unit holds own address
// - Addressed: only matching unit replies, at once
// - Broadcast processed from final byte received
// - Broadcast reply waits, lower address first
// - Slot delay is (response+reply length) times address
// - Response time 2.5 bytes plus margin
// - Address zero replies with no delay
// - Only data and ground; handshake looped back
// - Unit address range zero to 254
`timescale 1ns/10ps
`default_nettype none
`include "msr_params.svh"
module msr_responder (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Configuration
  input wire msr_pkg::msr_link_type link_mode_in,
  input wire logic [7:0] unit_bus_address_in,
  input wire logic [15:0] baud_div_in,
  // Serial pins
  input wire logic rx_in,
  input wire logic rts_in,
  output logic tx_out,
  output logic tx_oe_out,
  output logic cts_out,
  // Received bytes and end-of-message report
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  input wire msr_pkg::msr_msg_type msg_in,
  // Reply bytes
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  input wire logic tx_last_in,
  output logic tx_ready_out,
  output logic reply_grant_out
);

  // Next count of a bit-time divider, reloads on zero
  function automatic logic [15:0] msr_tick_next(input logic [15:0] cnt, input logic [15:0] div);
    return (cnt == `MSR_ZERO16) ? div - 16'h0001 : cnt - 16'h0001;
  endfunction : msr_tick_next

  // Broadcast wait in bit times for an address
  function automatic logic [15:0] msr_slot_delay(input logic [7:0] addr);
    logic [15:0] slot;
    slot = `MSR_TR_NOM_BITS + `MSR_TR_MARGIN_BITS + `MSR_ACK_LEN_BYTES * `MSR_BITS_PER_BYTE;
    return 16'(addr) * slot;
  endfunction : msr_slot_delay

  logic rx_meta_q, rx_sync_q, rts_meta_q, rts_sync_q;
  logic [15:0] div;
  logic [7:0] addr_clamp;
  logic [7:0] addr_q;

  // Config conditioning; a too-small divisor would stall the counters
  assign div = (baud_div_in < `MSR_DIV_MIN) ? `MSR_DIV_MIN : baud_div_in;
  assign addr_clamp = (unit_bus_address_in > `MSR_ADDR_MAX) ? `MSR_ADDR_MAX : unit_bus_address_in;

  // Pin synchronisers and config registers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_meta_q <= `MSR_LINE_IDLE;
      rx_sync_q <= `MSR_LINE_IDLE;
      rts_meta_q <= 1'b0;
      rts_sync_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (ce_in) begin
      rx_meta_q <= rx_in;
      rx_sync_q <= rx_meta_q;
      rts_meta_q <= rts_in;
      rts_sync_q <= rts_meta_q;
      addr_q <= addr_clamp;
    end
  end

  // Receiver: sample mid-bit, ten bit times per byte
  logic rx_busy_q, rx_busy_d;
  logic [15:0] rx_cnt_q, rx_cnt_d;
  logic [3:0] rx_bit_q, rx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d, rx_data_q, rx_data_d;
  logic rx_valid_q, rx_valid_d;

  always_comb begin
    rx_busy_d = rx_busy_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_data_d = rx_data_q;
    rx_valid_d = 1'b0;
    if (!rx_busy_q) begin
      if (!rx_sync_q) begin
        rx_busy_d = 1'b1;
        rx_cnt_d = {1'b0, div[15:1]} - 16'h0001;
        rx_bit_d = 4'h0;
      end
    end else if (rx_cnt_q == `MSR_ZERO16) begin
      rx_cnt_d = msr_tick_next(rx_cnt_q, div);
      if (rx_bit_q == 4'h0) begin
        // Start bit gone high again: a glitch, drop it
        if (rx_sync_q) begin
          rx_busy_d = 1'b0;
        end else begin
          rx_bit_d = 4'h1;
        end
      end else if (rx_bit_q == 4'h9) begin
        rx_busy_d = 1'b0;
        if (rx_sync_q) begin
          rx_valid_d = 1'b1;
          rx_data_d = rx_sh_q;
        end
      end else begin
        rx_sh_d = {rx_sync_q, rx_sh_q[7:1]};
        rx_bit_d = rx_bit_q + 4'h1;
      end
    end else begin
      rx_cnt_d = rx_cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= `MSR_ZERO16;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
    end else if (ce_in) begin
      rx_busy_q <= rx_busy_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_data_q <= rx_data_d;
      rx_valid_q <= rx_valid_d;
    end
  end

  assign rx_data_out = rx_data_q;
  assign rx_valid_out = rx_valid_q;

  // Reply scheduler
  msr_pkg::msr_resp_type state_q, state_d;
  logic [15:0] rem_q, rem_d, dly_cnt_q, dly_cnt_d;
  logic dly_tick, multidrop, tx_done, last_q, last_d;

  assign multidrop = (link_mode_in != msr_pkg::MSR_LINK_P2P);
  assign dly_tick = (dly_cnt_q == `MSR_ZERO16);

  always_comb begin
    state_d = state_q;
    rem_d = rem_q;
    dly_cnt_d = msr_tick_next(dly_cnt_q, div);
    // Each new message end restarts scheduling; host spacing keeps this rare
    if (msg_in.done) begin
      dly_cnt_d = div - 16'h0001;
      rem_d = `MSR_ZERO16;
      if (!multidrop) begin
        state_d = msr_pkg::MSR_GRANT;
      end else if (msg_in.bcast) begin
        rem_d = msr_slot_delay(addr_clamp);
        state_d = (rem_d == `MSR_ZERO16) ? msr_pkg::MSR_GRANT : msr_pkg::MSR_WAIT;
      end else if (msg_in.addr == addr_clamp) begin
        state_d = msr_pkg::MSR_GRANT;
      end else begin
        state_d = msr_pkg::MSR_IDLE;
      end
    end else begin
      case (state_q)
        msr_pkg::MSR_WAIT: begin
          if (dly_tick) begin
            rem_d = rem_q - 16'h0001;
            if (rem_q == 16'h0001) begin
              state_d = msr_pkg::MSR_GRANT;
            end
          end
        end
        msr_pkg::MSR_GRANT: begin
          if (tx_done && last_q) begin
            state_d = msr_pkg::MSR_IDLE;
          end
        end
        default: begin
          state_d = msr_pkg::MSR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= msr_pkg::MSR_IDLE;
      rem_q <= `MSR_ZERO16;
      dly_cnt_q <= `MSR_ZERO16;
    end else if (ce_in) begin
      state_q <= state_d;
      rem_q <= rem_d;
      dly_cnt_q <= dly_cnt_d;
    end
  end

  // Transmitter and line driver
  logic tx_busy_q, tx_busy_d, tx_q, tx_d, oe_q, oe_d, cts_q, cts_d, ready_q, ready_d, grant_q, grant_d;
  logic [15:0] tx_cnt_q, tx_cnt_d;
  logic [3:0] tx_bit_q, tx_bit_d;
  logic [9:0] tx_sh_q, tx_sh_d;
  logic accept;

  assign accept = tx_valid_in && ready_q;
  assign tx_done = tx_busy_q && (tx_cnt_q == `MSR_ZERO16) && (tx_bit_q == 4'h9);

  always_comb begin
    tx_busy_d = tx_busy_q;
    tx_cnt_d = tx_cnt_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    last_d = last_q;
    if (accept) begin
      // Only granted units ever load a byte
      tx_busy_d = 1'b1;
      tx_sh_d = {1'b1, tx_data_in, 1'b0};
      tx_cnt_d = div - 16'h0001;
      tx_bit_d = 4'h0;
      last_d = tx_last_in;
    end else if (tx_busy_q) begin
      tx_cnt_d = msr_tick_next(tx_cnt_q, div);
      if (tx_cnt_q == `MSR_ZERO16) begin
        tx_sh_d = {1'b1, tx_sh_q[9:1]};
        tx_bit_d = tx_bit_q + 4'h1;
        if (tx_done) begin
          tx_busy_d = 1'b0;
        end
      end
    end
    tx_d = tx_busy_d ? tx_sh_d[0] : `MSR_LINE_IDLE;
    // Shared bus: drive only while granted or finishing a byte
    oe_d = (link_mode_in == msr_pkg::MSR_LINK_P2P) || (state_d == msr_pkg::MSR_GRANT) || tx_busy_d;
    ready_d = (state_d == msr_pkg::MSR_GRANT) && !tx_busy_d;
    grant_d = (state_d == msr_pkg::MSR_GRANT);
    cts_d = rts_sync_q;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= `MSR_ZERO16;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 10'h3ff;
      last_q <= 1'b0;
      tx_q <= `MSR_LINE_IDLE;
      oe_q <= 1'b0;
      ready_q <= 1'b0;
      grant_q <= 1'b0;
      cts_q <= 1'b0;
    end else if (ce_in) begin
      tx_busy_q <= tx_busy_d;
      tx_cnt_q <= tx_cnt_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      last_q <= last_d;
      tx_q <= tx_d;
      oe_q <= oe_d;
      ready_q <= ready_d;
      grant_q <= grant_d;
      cts_q <= cts_d;
    end
  end

  assign tx_out = tx_q;
  assign tx_oe_out = oe_q;
  assign tx_ready_out = ready_q;
  assign reply_grant_out = grant_q;
  assign cts_out = cts_q;

  // Checks on scheduling and line behaviour
  property p_p2p_grant;
    @(posedge clk_in) disable iff (!rstn_in)
    (ce_in && msg_in.done && link_mode_in == msr_pkg::MSR_LINK_P2P) |=> reply_grant_out;
  endproperty
  a_p2p_grant: assert property (p_p2p_grant) else $error("point-to-point message not granted");
  property p_addr_match;
    @(posedge clk_in) disable iff (!rstn_in)
    (ce_in && msg_in.done && multidrop && !msg_in.bcast && msg_in.addr == addr_clamp) |=> reply_grant_out;
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("matching unit did not reply at once");
  property p_addr_silent;
    @(posedge clk_in) disable iff (!rstn_in)
    (ce_in && msg_in.done && multidrop && !msg_in.bcast && msg_in.addr != addr_clamp && !tx_busy_q)
      |=> (!tx_oe_out && !tx_ready_out);
  endproperty
  a_addr_silent: assert property (p_addr_silent) else $error("unaddressed unit drives the bus");
  property p_zero_addr;
    @(posedge clk_in) disable iff (!rstn_in)
    (ce_in && msg_in.done && multidrop && msg_in.bcast && addr_clamp == 8'h00) |=> reply_grant_out;
  endproperty
  a_zero_addr: assert property (p_zero_addr) else $error("address zero delayed its reply");
  property p_bcast_load;
    @(posedge clk_in) disable iff (!rstn_in)
    (ce_in && msg_in.done && multidrop && msg_in.bcast && addr_clamp != 8'h00)
      |=> (state_q == msr_pkg::MSR_WAIT && rem_q == msr_slot_delay($past(addr_clamp)) && !reply_grant_out);
  endproperty
  a_bcast_load: assert property (p_bcast_load) else $error("broadcast wait not loaded from address");
  property p_wait_hold;
    @(posedge clk_in) disable iff (!rstn_in)
    (ce_in && !msg_in.done && state_q == msr_pkg::MSR_WAIT && rem_q > 16'h0001) |=> !reply_grant_out;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("reply granted before slot delay ended");
  property p_wait_end;
    @(posedge clk_in) disable iff (!rstn_in)
    (ce_in && !msg_in.done && state_q == msr_pkg::MSR_WAIT && rem_q == 16'h0001 && dly_tick) |=> reply_grant_out;
  endproperty
  a_wait_end: assert property (p_wait_end) else $error("grant missing when slot delay ended");
  property p_tx_gated;
    @(posedge clk_in) disable iff (!rstn_in)
    (tx_valid_in && tx_ready_out) |-> (state_q == msr_pkg::MSR_GRANT && tx_oe_out);
  endproperty
  a_tx_gated: assert property (p_tx_gated) else $error("byte accepted outside reply window");
  // Loopback follows the synchronised line in both directions, one cycle behind
  property p_cts_loop;
    @(posedge clk_in) disable iff (!rstn_in)
    ce_in |=> (cts_out == $past(rts_sync_q));
  endproperty
  a_cts_loop: assert property (p_cts_loop) else $error("handshake loopback broken");
  property p_addr_range;
    @(posedge clk_in) disable iff (!rstn_in)
    addr_q <= `MSR_ADDR_MAX;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("unit address out of range");

endmodule : msr_responder
`default_nettype wire

// File: msr_host_model.sv
// Host computer model on the shared serial bus of the responder
`timescale 1ns/10ps
`default_nettype none
module msr_host_model #(
  parameter int DIV = 4
) (
  // Clock and bus lines
  input wire logic clk_in,
  input wire logic tx_in,
  output logic rx_out
);
  logic [7:0] got_q;
  int n_got;
  // Line idles high; only data lines, no handshake
  initial begin
    rx_out = 1'b1;
    got_q = 8'h00;
    n_got = 0;
  end
  // Start, eight data bits LSB first, stop: ten bit times
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_out = f[i];
      repeat (DIV) @(posedge clk_in);
      #2;
    end
  endtask : send_byte
  // Reply collector, samples at mid-bit to ride out edge skew
  initial begin
    forever begin
      @(negedge tx_in);
      repeat (DIV + DIV / 2) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
        got_q[i] = tx_in;
        repeat (DIV) @(posedge clk_in);
      end
      n_got++;
    end
  end
endmodule : msr_host_model
`default_nettype wire

// File: tb_msr_responder.sv
// Self-checking bench for the multidrop serial responder
`timescale 1ns/10ps
`default_nettype none
module tb_msr_responder;
  localparam int DIV = 4;
  typedef struct packed {
    msr_pkg::msr_link_type mode;
    logic [7:0] own;
    logic bc;
    logic [7:0] ma;
    logic gr;
  } msr_row_type;
  logic clk_in, rstn_in, ce_in, rx_in, rts_in, tx_valid_in, tx_last_in;
  msr_pkg::msr_link_type link_mode_in;
  logic [7:0] unit_bus_address_in, tx_data_in, rx_data_out;
  logic [15:0] baud_div_in;
  msr_pkg::msr_msg_type msg_in;
  logic tx_out, tx_oe_out, cts_out, rx_valid_out, tx_ready_out, reply_grant_out, bus_line;
  int err_total, n_compared, t;
  msr_row_type rows [6];
  // Released bus is biased to idle high
  assign bus_line = tx_oe_out ? tx_out : 1'b1;
  msr_responder msr_responder_inst (.clk_in, .rstn_in, .ce_in, .link_mode_in, .unit_bus_address_in,
    .baud_div_in, .rx_in, .rts_in, .tx_out, .tx_oe_out, .cts_out, .rx_data_out, .rx_valid_out,
    .msg_in, .tx_data_in, .tx_valid_in, .tx_last_in, .tx_ready_out, .reply_grant_out);
  msr_host_model #(.DIV(DIV)) msr_host_model_inst (.clk_in(clk_in), .tx_in(bus_line), .rx_out(rx_in));
  // 40 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One cycle step; a used-up bound ends the run
  task automatic step(input int lim);
    @(posedge clk_in);
    #2;
    t++;
    if (t > lim) begin
      err_total++;
      finish_test();
    end
  endtask : step
  task automatic pulse_done(input logic bc, input logic [7:0] ma);
    msg_in = '{1'b1, bc, ma};
    @(posedge clk_in);
    #2;
    msg_in.done = 1'b0;
  endtask : pulse_done
  // Offer one last byte, hold until taken, then wait for window close
  task automatic send_reply(input logic [7:0] b, input logic oe);
    int n0;
    n0 = msr_host_model_inst.n_got;
    tx_data_in = b;
    tx_valid_in = 1'b1;
    tx_last_in = 1'b1;
    t = 0;
    while (tx_ready_out !== 1'b0) step(50);
    tx_valid_in = 1'b0;
    tx_last_in = 1'b0;
    t = 0;
    while (reply_grant_out !== 1'b0) step(12 * DIV);
    repeat (2) @(posedge clk_in);
    #2;
    check(msr_host_model_inst.got_q, b);
    check(16'(msr_host_model_inst.n_got), 16'(n0 + 1));
    check(tx_oe_out, oe);
  endtask : send_reply
  initial begin
    rows[0] = '{msr_pkg::MSR_LINK_P2P, 8'h05, 1'b0, 8'h09, 1'b1};
    rows[1] = '{msr_pkg::MSR_LINK_FULL, 8'h05, 1'b0, 8'h05, 1'b1};
    rows[2] = '{msr_pkg::MSR_LINK_HALF, 8'h05, 1'b0, 8'h06, 1'b0};
    rows[3] = '{msr_pkg::MSR_LINK_HALF, 8'h00, 1'b1, 8'h00, 1'b1};
    rows[4] = '{msr_pkg::MSR_LINK_FULL, 8'hfe, 1'b0, 8'hfe, 1'b1};
    rows[5] = '{msr_pkg::MSR_LINK_HALF, 8'hff, 1'b0, 8'hfe, 1'b1};
    err_total = 0;
    n_compared = 0;
    rstn_in = 1'b0;
    ce_in = 1'b1;
    rts_in = 1'b0;
    link_mode_in = msr_pkg::MSR_LINK_HALF;
    unit_bus_address_in = 8'h00;
    baud_div_in = 16'(DIV);
    msg_in = '0;
    tx_data_in = 8'h00;
    tx_valid_in = 1'b0;
    tx_last_in = 1'b0;
    repeat (16) @(posedge clk_in);
    #2;
    // Outputs quiet while held in reset
    check({tx_out, tx_oe_out, reply_grant_out, tx_ready_out}, 16'h0008);
    rstn_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #2;
    // Table of message cases
    for (int i = 0; i < 6; i++) begin
      link_mode_in = rows[i].mode;
      unit_bus_address_in = rows[i].own;
      repeat (3) @(posedge clk_in);
      #2;
      pulse_done(rows[i].bc, rows[i].ma);
      check(reply_grant_out, rows[i].gr);
      check(tx_oe_out, rows[i].gr | (rows[i].mode == msr_pkg::MSR_LINK_P2P));
      if (rows[i].gr) send_reply(8'h30 + 8'(i), rows[i].mode == msr_pkg::MSR_LINK_P2P);
    end
    // Handshake lines only looped back
    rts_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #2;
    check(cts_out, 1'b1);
    rts_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #2;
    check(cts_out, 1'b0);
    // Enable low freezes the loopback path as well
    ce_in = 1'b0;
    rts_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #2;
    check(cts_out, 1'b0);
    ce_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #2;
    check(cts_out, 1'b1);
    rts_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #2;
    // Received byte; pulse lands inside the frame so poll alongside
    t = 0;
    fork
      msr_host_model_inst.send_byte(8'ha5);
      while (rx_valid_out !== 1'b1) step(14 * DIV);
    join
    check(rx_data_out, 8'ha5);
    // Broadcast slot for address 2: ninety bit times per slot
    link_mode_in = msr_pkg::MSR_LINK_HALF;
    unit_bus_address_in = 8'h02;
    repeat (3) @(posedge clk_in);
    #2;
    pulse_done(1'b1, 8'h00);
    check(reply_grant_out, 1'b0);
    t = 1;
    while (reply_grant_out !== 1'b1) step(3 * 90 * DIV);
    check(t >= 2 * 90 * DIV - 1 && t <= 2 * 90 * DIV + 1, 1'b1);
    send_reply(8'h5a, 1'b0);
    // Host spacing: five byte times
    repeat (50 * DIV) @(posedge clk_in);
    #2;
    unit_bus_address_in = 8'h00;
    pulse_done(1'b1, 8'h00);
    check(reply_grant_out, 1'b1);
    send_reply(8'hc3, 1'b0);
    // Reset in mid-wait drops the pending slot; host spacing kept first
    repeat (230 * DIV) @(posedge clk_in);
    #2;
    unit_bus_address_in = 8'h03;
    pulse_done(1'b1, 8'h00);
    check(reply_grant_out, 1'b0);
    repeat (20) @(posedge clk_in);
    #2;
    rstn_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #2;
    check({tx_out, tx_oe_out, reply_grant_out, tx_ready_out}, 16'h0008);
    rstn_in = 1'b1;
    repeat (3 * 90 * DIV + 8) @(posedge clk_in);
    #2;
    check(reply_grant_out, 1'b0);
    // Addressed traffic works again after the reset
    pulse_done(1'b0, 8'h03);
    check(reply_grant_out, 1'b1);
    send_reply(8'h96, 1'b0);
    finish_test();
  end
endmodule : tb_msr_responder
`default_nettype wire
